// file: spi_nv_cfg.svh
`ifndef SPI_NV_CFG_SVH
`define SPI_NV_CFG_SVH
// Opcodes
`define OP_WREN          8'h06
`define OP_WRDI          8'h04
`define OP_RDSR          8'h05
`define OP_WRSR          8'h01
`define OP_READ          8'h03
`define OP_WRITE         8'h02
`define OP_READ_CLOCK_REGS 8'h13
`define OP_WRTC          8'h12
`define OP_STORE         8'h3c
`define OP_RECALL        8'h60
`define OP_AUTOSAVE_EN   8'h59
`define OP_AUTOSAVE_DIS  8'h19
// Timing, in ns, and the clock period
`define MCLK_PERIOD_NS   100
`define PWRUP_RECALL_NS  20000
`define SW_RECALL_NS     30000
// Reset values
`define AUTOSAVE_RST     1'b1
`define STATUS_RST       8'h00
// Status field position
`define ST_RDY_BIT       0
// Address bytes per memory access
`define ADDR_BYTES       2'h2
`endif

// file: spi_nv_pkg.sv
package spi_nv_pkg;
   // Decoder phase within one select period
   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,  // Deselected
      PH_OPCODE = 3'b001,  // Collecting the opcode
      PH_ADDR   = 3'b010,  // Collecting address bytes
      PH_DATA   = 3'b011,  // Data phase of a transfer
      PH_IGNORE = 3'b100   // Discard until select rises
   } phase_t;
endpackage : spi_nv_pkg

// file: spi_nv_front.sv
// What this block does
// - Power-up starts a recall into SRAM
// - Power-up recall blocks access, drives busy pin
// - Recall opcode runs recall, blocks memory access
// - Disable opcode suppresses power-down store
// - Enable opcode restores power-down store
// - Autosave setting volatile; store makes it stick (not kept here: reset always loads autosave on)
// - Delivered state: autosave on, cells zero
// - Power-up recall can never be suppressed
// - First byte after select is the opcode
// - One opcode per select period
// - Deselected: ignore input, output tristated
// - Sample on rising, drive on falling edge
// - All bytes shifted most significant first
// - Memory accesses carry two address bytes
// - Unknown opcode: ignore rest, stay tristated
// - Clock level at select fall picks mode
// - Mode 3 first bit after clock goes low
// - Stay deselected until a select falling edge
// - Eight-bit status register present
// - Status ready bit set while busy
// - Busy pin pulled low during store
`timescale 1ns/100ps
`default_nettype none
`include "spi_nv_cfg.svh"

module byte_fifo #(
   parameter int W     = 9,   // Word width
   parameter int DEPTH = 32   // Number of words
) (
   input  wire logic         mclk,      // Block clock
   input  wire logic         sys_rst,   // Synchronous reset
   input  wire logic         in_valid,  // Word offered
   output logic              in_ready,  // Room for a word
   input  wire logic [W-1:0] in_data,   // Word in
   output logic              out_valid, // Word available
   input  wire logic         out_ready, // Drain takes word
   output logic [W-1:0]      out_data   // Word out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;  // Storage
      logic [AW-1:0]           wr;   // Write index
      logic [AW-1:0]           rd;   // Read index
      logic [AW:0]             cnt;  // Words held
   } fifo_st_t;

   fifo_st_t s_q, s_d;
   logic     push, pop;

   assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer wrap works for any depth, not only powers of two
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
   endfunction : bump

   // Next state of the queue
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr          = bump(s_q.wr);
      end
      if (pop)
         s_d.rd = bump(s_q.rd);
      if (push && !pop)
         s_d.cnt = s_q.cnt + 1'b1;
      else if (pop && !push)
         s_d.cnt = s_q.cnt - 1'b1;
   end

   // Reset clears the storage, both pointers and the count
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q.mem <= '0;
         s_q.wr  <= '0;
         s_q.rd  <= '0;
         s_q.cnt <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : byte_fifo

module spi_nv_front #(
   parameter int PWRUP_CYC  = (`PWRUP_RECALL_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS, // Power-up recall
   parameter int RECALL_CYC = (`SW_RECALL_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,    // Software recall
   parameter int FIFO_DEPTH = 32                                                          // Write queue depth
) (
   input  wire logic       mclk,                // 10 MHz block clock
   input  wire logic       sys_rst,             // Power-on reset, synchronous
   input  wire logic       cs_n_pin,            // Chip select, active low
   input  wire logic       sck_pin,             // Serial clock from master
   input  wire logic       si_pin,              // Serial data in
   output logic            so_o,                // Serial data out
   output logic            so_oe_n,             // Low while driving serial out
   output logic            store_busy_pin_o,    // Busy pin drive level (0)
   output logic            store_busy_pin_oe_n, // Low while pulling busy pin
   input  wire logic       pwr_fail_pin,        // Supply dropped below threshold
   input  wire logic       store_active,        // A store is in progress
   output logic            pd_store_req,        // Pulse: start power-down store
   output logic            autosave_en,         // Power-down store enabled
   output logic            recall_busy,         // Recall in progress
   output logic [7:0]      status,              // Status register image
   output logic            mode3,               // Mode 3 detected at select
   output logic            op_strobe,           // Pulse: opcode for outer logic
   output logic [7:0]      opcode,              // Last opcode received, known or not
   output logic            rd_req,              // Pulse: fetch byte at rd_addr
   output logic [15:0]     rd_addr,             // Read address
   input  wire logic [7:0] tx_byte,             // Read data for rd_addr
   output logic            rx_valid,            // Write-queue word available
   input  wire logic       rx_ready,            // Drain takes the word
   output logic [8:0]      rx_data,             // {address flag, byte}
   output logic            rx_overflow          // Sticky: byte lost, queue full
);
   typedef struct packed {
      logic [1:0]          cs_sy;    // Select synchroniser
      logic [1:0]          sck_sy;   // Clock synchroniser
      logic [1:0]          si_sy;    // Data synchroniser
      logic [1:0]          pf_sy;    // Power-fail synchroniser
      logic                cs_prev;  // Select one sample ago
      logic                sck_prev; // Clock one sample ago
      logic                pf_prev;  // Power fail one sample ago
      spi_nv_pkg::phase_t  ph;       // Decoder phase
      logic [7:0]          sh;       // Input shifter
      logic [2:0]          bitc;     // Bits in this byte
      logic [1:0]          abyte;    // Address bytes seen
      logic [7:0]          op;       // Opcode of this period
      logic                send;     // Output phase active
      logic                from_sr;  // Output source is status
      logic [7:0]          txsh;     // Output shifter
      logic                so;       // Serial out level
      logic                so_oe_n;  // Serial out enable, low active
      logic                bsy_oe_n; // Busy pin enable, low active
      logic [19:0]         rcnt;     // Recall countdown
      logic                rbusy;    // Recall in progress
      logic                as_en;    // Autosave enable
      logic                as_req;   // Autosave request pulse
      logic [7:0]          stat;     // Status register
      logic                mode3;    // Mode 3 latched
      logic                ostb;     // Opcode strobe
      logic                rreq;     // Read fetch strobe
      logic [15:0]         raddr;    // Read address
      logic                pvld;     // Pending queue word
      logic [8:0]          pdat;     // Pending queue word data
      logic                ovf;      // Sticky overflow
   } front_st_t;

   front_st_t s_q, s_d;
   logic      q_ready;  // Queue accepts the pending word

   byte_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_q (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (s_q.pvld),
      .in_ready  (q_ready),
      .in_data   (s_q.pdat),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // Opcodes handed to outer logic; anything else is unknown
   function automatic logic known_op(input logic [7:0] o);
      return o == `OP_WREN || o == `OP_WRDI || o == `OP_RDSR || o == `OP_WRSR ||
             o == `OP_READ || o == `OP_WRITE || o == `OP_READ_CLOCK_REGS || o == `OP_WRTC ||
             o == `OP_STORE || o == `OP_RECALL || o == `OP_AUTOSAVE_EN ||
             o == `OP_AUTOSAVE_DIS;
   endfunction : known_op

   // Memory or clock-register accesses carry an address
   function automatic logic addr_op(input logic [7:0] o);
      return o == `OP_READ || o == `OP_WRITE || o == `OP_READ_CLOCK_REGS || o == `OP_WRTC;
   endfunction : addr_op

   function automatic logic read_op(input logic [7:0] o);
      return o == `OP_READ || o == `OP_READ_CLOCK_REGS;
   endfunction : read_op

   // Next state of the whole front end
   always_comb begin
      logic       sel, cs_fall, rise, fall, pf_rise, done, busy;
      logic [7:0] byte_in, src;
      s_d        = s_q;
      s_d.cs_sy  = {s_q.cs_sy[0], cs_n_pin};
      s_d.sck_sy = {s_q.sck_sy[0], sck_pin};
      s_d.si_sy  = {s_q.si_sy[0], si_pin};
      s_d.pf_sy  = {s_q.pf_sy[0], pwr_fail_pin};
      s_d.cs_prev  = s_q.cs_sy[1];
      s_d.sck_prev = s_q.sck_sy[1];
      s_d.pf_prev  = s_q.pf_sy[1];
      s_d.ostb   = 1'b0;
      s_d.rreq   = 1'b0;
      s_d.as_req = 1'b0;
      sel      = ~s_q.cs_sy[1];
      cs_fall  = s_q.cs_prev & ~s_q.cs_sy[1];
      rise     = sel & ~s_q.sck_prev & s_q.sck_sy[1];
      fall     = sel & s_q.sck_prev & ~s_q.sck_sy[1];
      pf_rise  = s_q.pf_sy[1] & ~s_q.pf_prev;
      byte_in  = {s_q.sh[6:0], s_q.si_sy[1]};
      done     = rise && (s_q.bitc == 3'h7);
      busy     = s_q.rbusy | store_active;
      src      = s_q.from_sr ? s_q.stat : tx_byte;

      // Recall countdown; memory opens when it expires
      if (s_q.rbusy) begin
         if (s_q.rcnt <= 20'h1)
            s_d.rbusy = 1'b0;
         else
            s_d.rcnt = s_q.rcnt - 20'h1;
      end

      // Power-down store only when enabled
      if (pf_rise && s_q.as_en && !store_active)
         s_d.as_req = 1'b1;

      // Queue hand-off; the pending word stalls until there is room
      if (s_q.pvld && q_ready)
         s_d.pvld = 1'b0;

      if (!sel || s_q.ph == spi_nv_pkg::PH_IDLE) begin
         // Deselected: input ignored, decoder cleared, output tristated
         s_d.sh      = 8'h00;
         s_d.bitc    = 3'h0;
         s_d.abyte   = 2'h0;
         s_d.send    = 1'b0;
         s_d.so_oe_n = 1'b1;
         s_d.ph      = spi_nv_pkg::PH_IDLE;
         if (cs_fall) begin
            s_d.ph    = spi_nv_pkg::PH_OPCODE;
            s_d.mode3 = s_q.sck_sy[1];
         end
      end else begin
         if (rise) begin
            s_d.sh   = byte_in;
            s_d.bitc = s_q.bitc + 3'h1;
         end
         unique case (s_q.ph)
            spi_nv_pkg::PH_OPCODE: begin
               if (done) begin
                  s_d.op = byte_in;
                  s_d.ph = spi_nv_pkg::PH_IGNORE;
                  if (known_op(byte_in))
                     s_d.ostb = 1'b1;
                  if (addr_op(byte_in) && !busy)
                     s_d.ph = spi_nv_pkg::PH_ADDR;
                  if (byte_in == `OP_RDSR) begin
                     s_d.ph      = spi_nv_pkg::PH_DATA;
                     s_d.send    = 1'b1;
                     s_d.from_sr = 1'b1;
                  end
                  if (byte_in == `OP_RECALL && !busy) begin
                     s_d.rbusy = 1'b1;
                     s_d.rcnt  = 20'(RECALL_CYC);
                  end
                  if (byte_in == `OP_AUTOSAVE_DIS)
                     s_d.as_en = 1'b0;
                  if (byte_in == `OP_AUTOSAVE_EN)
                     s_d.as_en = 1'b1;
               end
            end
            spi_nv_pkg::PH_ADDR: begin
               if (done) begin
                  s_d.raddr = {s_q.raddr[7:0], byte_in};
                  s_d.abyte = s_q.abyte + 2'h1;
                  if (s_q.op == `OP_WRITE || s_q.op == `OP_WRTC) begin
                     s_d.ovf  = s_q.ovf | s_q.pvld;
                     s_d.pvld = 1'b1;
                     s_d.pdat = {1'b1, byte_in};
                  end
                  if (s_q.abyte == `ADDR_BYTES - 2'h1) begin
                     s_d.ph = spi_nv_pkg::PH_DATA;
                     if (read_op(s_q.op)) begin
                        s_d.send    = 1'b1;
                        s_d.from_sr = 1'b0;
                        s_d.rreq    = 1'b1;
                     end
                  end
               end
            end
            spi_nv_pkg::PH_DATA: begin
               if (done) begin
                  if (s_q.send && !s_q.from_sr) begin
                     s_d.raddr = s_q.raddr + 16'h1;  // Rolls over at the top
                     s_d.rreq  = 1'b1;
                  end else if (!s_q.send) begin
                     s_d.ovf  = s_q.ovf | s_q.pvld;
                     s_d.pvld = 1'b1;
                     s_d.pdat = {1'b0, byte_in};
                  end
               end
            end
            spi_nv_pkg::PH_IGNORE: begin
               s_d.so_oe_n = 1'b1;
            end
            spi_nv_pkg::PH_IDLE: begin
               s_d.ph = spi_nv_pkg::PH_IDLE;
            end
            default: begin
               s_d.ph = spi_nv_pkg::PH_IGNORE;
            end
         endcase
         // Output changes on falling edges; a byte is loaded at bit count 0, bit 7 first
         if (fall && s_q.send && s_q.ph == spi_nv_pkg::PH_DATA) begin
            s_d.so_oe_n = 1'b0;
            if (s_q.bitc == 3'h0) begin
               s_d.so   = src[7];
               s_d.txsh = {src[6:0], 1'b0};
            end else begin
               s_d.so   = s_q.txsh[7];
               s_d.txsh = {s_q.txsh[6:0], 1'b0};
            end
         end
      end

      // Status and busy pin follow recall and store activity
      s_d.stat                 = `STATUS_RST;
      s_d.stat[`ST_RDY_BIT]    = s_d.rbusy | store_active;
      s_d.bsy_oe_n             = ~(s_d.rbusy | store_active);
   end

   // Reset stands for power-up: recall always starts here
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q          <= '0;
         s_q.cs_prev  <= 1'b0;
         s_q.ph       <= spi_nv_pkg::PH_IDLE;
         s_q.so_oe_n  <= 1'b1;
         s_q.bsy_oe_n <= 1'b0;
         s_q.rbusy    <= 1'b1;
         s_q.rcnt     <= 20'(PWRUP_CYC);
         s_q.as_en    <= `AUTOSAVE_RST;
         s_q.stat     <= `STATUS_RST | 8'h01;
      end else begin
         s_q <= s_d;
      end
   end

   assign so_o                = s_q.so;
   assign so_oe_n             = s_q.so_oe_n;
   assign store_busy_pin_o    = 1'b0;
   assign store_busy_pin_oe_n = s_q.bsy_oe_n;
   assign pd_store_req        = s_q.as_req;
   assign autosave_en         = s_q.as_en;
   assign recall_busy         = s_q.rbusy;
   assign status              = s_q.stat;
   assign mode3               = s_q.mode3;
   assign op_strobe           = s_q.ostb;
   assign opcode              = s_q.op;
   assign rd_req              = s_q.rreq;
   assign rd_addr             = s_q.raddr;
   assign rx_overflow         = s_q.ovf;
endmodule : spi_nv_front
`default_nettype wire

// file: spi_nv_front_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "spi_nv_cfg.svh"
module spi_nv_front_properties (
   input wire logic       mclk,                // Block clock
   input wire logic       sys_rst,             // Synchronous reset
   input wire logic       cs_n_pin,            // Select pin
   input wire logic       so_oe_n,             // Low while driving out
   input wire logic       store_busy_pin_oe_n, // Low while busy
   input wire logic       store_active,        // Store running
   input wire logic       pd_store_req,        // Store request pulse
   input wire logic       autosave_en,         // Autosave state
   input wire logic       recall_busy,         // Recall running
   input wire logic [7:0] status,              // Status image
   input wire logic       op_strobe,           // Opcode pulse
   input wire logic [7:0] opcode,              // Last opcode
   input wire logic       rd_req               // Read fetch pulse
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // An opcode of the given value has just been accepted
   sequence s_op(logic [7:0] op);
      op_strobe && opcode == op;
   endsequence
   // Deselected long enough to pass the pin synchroniser
   sequence s_idle;
      cs_n_pin [*6];
   endsequence
   property p_tristate; s_idle |-> so_oe_n; endproperty
   property p_known;
      op_strobe |-> opcode inside {`OP_WREN, `OP_WRDI, `OP_RDSR, `OP_WRSR, `OP_READ, `OP_WRITE, `OP_READ_CLOCK_REGS,
                                   `OP_WRTC, `OP_STORE, `OP_RECALL, `OP_AUTOSAVE_EN, `OP_AUTOSAVE_DIS};
   endproperty
   property p_one_op; op_strobe |=> !op_strobe [*8]; endproperty
   property p_sel; op_strobe |-> !$past(cs_n_pin, 3); endproperty
   property p_recall;
      s_op(`OP_RECALL) ##0 !$past(recall_busy || store_active) |-> recall_busy;
   endproperty
   property p_rd_block; rd_req |-> !recall_busy; endproperty
   property p_dis; s_op(`OP_AUTOSAVE_DIS) |-> ##[0:2] !autosave_en; endproperty
   property p_en; s_op(`OP_AUTOSAVE_EN) |-> ##[0:2] autosave_en; endproperty
   // The request is launched from the state of the cycle before
   property p_gate; pd_store_req |-> $past(autosave_en) && !$past(store_active); endproperty
   property p_pulse; pd_store_req |=> !pd_store_req; endproperty
   property p_rdy; recall_busy && $past(recall_busy) |-> status[0]; endproperty
   property p_rsv; status[7:1] == 7'h00; endproperty
   property p_busy_pin; store_active ##1 store_active |-> !store_busy_pin_oe_n; endproperty
   a_tristate: assert property (p_tristate) else $error("serial out driven while deselected");
   a_known: assert property (p_known) else $error("strobe for an unknown opcode");
   a_one_op: assert property (p_one_op) else $error("second opcode strobe too soon");
   a_sel: assert property (p_sel) else $error("opcode strobe without select");
   a_recall: assert property (p_recall) else $error("recall opcode did not start recall");
   a_rd_block: assert property (p_rd_block) else $error("read fetch during recall");
   a_dis: assert property (p_dis) else $error("autosave not disabled");
   a_en: assert property (p_en) else $error("autosave not enabled");
   a_gate: assert property (p_gate) else $error("store request while disabled");
   a_pulse: assert property (p_pulse) else $error("store request longer than one cycle");
   a_rdy: assert property (p_rdy) else $error("ready bit clear during recall");
   a_rsv: assert property (p_rsv) else $error("status upper bits not zero");
   a_busy_pin: assert property (p_busy_pin) else $error("busy pin released during store");
endmodule : spi_nv_front_properties
bind spi_nv_front spi_nv_front_properties i_spi_nv_front_properties (
   .mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .so_oe_n(so_oe_n),
   .store_busy_pin_oe_n(store_busy_pin_oe_n), .store_active(store_active), .pd_store_req(pd_store_req),
   .autosave_en(autosave_en), .recall_busy(recall_busy), .status(status), .op_strobe(op_strobe),
   .opcode(opcode), .rd_req(rd_req));
`default_nettype wire

// file: spi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
   input  wire logic mclk,     // Block clock, paces the link
   input  wire logic so_o,     // Serial out level
   input  wire logic so_oe_n,  // Serial out enable
   output var logic  cs_n_pin, // Chip select
   output var logic  sck_pin,  // Serial clock
   output var logic  si_pin    // Serial data
);
   logic m3_q = 1'b0; // Park level of the frame in progress
   // Select starts low: the slave must not take that as a selection
   initial begin
      cs_n_pin = 1'b0;
      sck_pin  = 1'b0;
      si_pin   = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_clk
   // Park the clock for the mode, then open the frame
   task automatic sel(input logic m3);
      m3_q = m3;
      sck_pin <= m3;
      wait_clk(4);
      cs_n_pin <= 1'b0; // New frame on a falling select
      wait_clk(4);
   endtask : sel
   // One byte each way; 800 ns bit time, slower than either limit
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_pin <= 1'b0;
         si_pin  <= tx[i];
         wait_clk(4);
         sck_pin <= 1'b1;
         wait_clk(4);
         // Sampled late in the high phase, where SO has settled
         rx[i] = so_oe_n ? 1'bx : so_o;
      end
   endtask : xfer
   // Close the frame; the released data line must not show the last bit
   task automatic desel;
      sck_pin <= m3_q;
      si_pin  <= ~si_pin;
      wait_clk(4);
      cs_n_pin <= 1'b1;
      wait_clk(6);
   endtask : desel
endmodule : spi_master_model
`default_nettype wire

// file: spi_nv_front_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "spi_nv_cfg.svh"
module spi_nv_front_tb;
   localparam int PWR = 10;  // Short power-up recall
   localparam int REC = 400; // Long enough to try a read inside it
   logic        mclk, sys_rst, pwr_fail_pin, store_active, rx_ready; // Bench driven
   logic        cs_n_pin, sck_pin, si_pin, so_o, so_oe_n;            // Link
   logic        store_busy_pin_o, store_busy_pin_oe_n, pd_store_req;  // Store side
   logic        autosave_en, recall_busy, mode3, op_strobe, rd_req;  // Status
   logic        rx_valid, rx_overflow;                               // Queue flags
   logic [7:0]  status, opcode;                                      // Images
   logic [7:0]  tx_byte = 8'h00;                                     // Read data
   logic [15:0] rd_addr;                                             // Read address
   logic [8:0]  rx_data;                                             // Queue word
   logic [8:0]  popq[$];                                             // Drained words
   logic [7:0]  rxq[$];                                              // Bytes on SO
   int          errors = 0, check_count = 0, n_strobe = 0, n_auto = 0, n_rd = 0;
   spi_nv_front #(.PWRUP_CYC(PWR), .RECALL_CYC(REC), .FIFO_DEPTH(32)) i_spi_nv_front (
      .mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
      .so_o(so_o), .so_oe_n(so_oe_n), .store_busy_pin_o(store_busy_pin_o),
      .store_busy_pin_oe_n(store_busy_pin_oe_n), .pwr_fail_pin(pwr_fail_pin), .store_active(store_active),
      .pd_store_req(pd_store_req), .autosave_en(autosave_en), .recall_busy(recall_busy), .status(status),
      .mode3(mode3), .op_strobe(op_strobe), .opcode(opcode), .rd_req(rd_req), .rd_addr(rd_addr),
      .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_overflow(rx_overflow));
   spi_master_model i_spi_master_model (
      .mclk(mclk), .so_o(so_o), .so_oe_n(so_oe_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Count pulses, drain the queue, serve read data derived from the address
   always @(posedge mclk) begin
      if (op_strobe === 1'b1) n_strobe <= n_strobe + 1;
      if (pd_store_req === 1'b1) n_auto <= n_auto + 1;
      if (rd_req === 1'b1) n_rd <= n_rd + 1;
      if (rd_req === 1'b1) tx_byte <= rd_addr[7:0] ^ 8'hc3;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) popq.push_back(rx_data);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   // Whole frame; bytes returned on SO land in rxq
   task automatic frame(input logic m3, input logic [7:0] tx[$]);
      logic [7:0] r;
      rxq = {};
      i_spi_master_model.sel(m3);
      foreach (tx[i]) begin
         i_spi_master_model.xfer(tx[i], r);
         rxq.push_back(r);
      end
      i_spi_master_model.desel();
   endtask : frame
   task automatic t_powerup;
      logic [7:0] r;
      check(recall_busy, 1);
      check(status, 8'h01);
      check(store_busy_pin_oe_n, 0);
      check(autosave_en, 1);
      check(so_oe_n, 1);
      repeat (PWR + 6) @(posedge mclk);
      check(recall_busy, 0);
      check(store_busy_pin_oe_n, 1);
      // Select has been low since power-up, so this byte must be ignored
      i_spi_master_model.xfer(`OP_WREN, r);
      i_spi_master_model.desel();
      check(n_strobe, 0);
      $display("Test powerup done");
   endtask : t_powerup
   task automatic t_write_queue;
      logic [7:0] tx[$];
      rx_ready <= 1'b0;
      tx = {`OP_WRITE, 8'h12, 8'h34};
      for (int i = 0; i < 35; i++) tx.push_back(8'(i));
      frame(1'b1, tx);
      check(mode3, 1);
      check(opcode, `OP_WRITE);
      check(rx_overflow, 1);
      rx_ready <= 1'b1;
      repeat (40) @(posedge mclk);
      check(popq.size(), 33);
      check(popq[0], 9'h112);
      check(popq[1], 9'h134);
      check(popq[2], 9'h000);
      check(popq[32], 9'h022); // Pending word keeps the newest byte
      check(rx_valid, 0);
      $display("Test write queue done");
   endtask : t_write_queue
   task automatic t_read;
      frame(1'b0, {`OP_READ, 8'hff, 8'hff, 8'h00, 8'h00});
      check(mode3, 0);
      check(rxq[3], 8'h3c);
      check(rxq[4], 8'hc3); // Address wrapped to zero
      $display("Test read done");
   endtask : t_read
   task automatic t_recall;
      int n0;
      frame(1'b0, {`OP_RECALL});
      check(recall_busy, 1);
      check(status, 8'h01);
      n0 = n_rd;
      frame(1'b0, {`OP_READ, 8'h00, 8'h00, 8'h00});
      check(n_rd, n0);
      repeat (REC) @(posedge mclk); // Master waits out the recall
      check(recall_busy, 0);
      $display("Test recall done");
   endtask : t_recall
   task automatic t_autosave;
      frame(1'b0, {`OP_AUTOSAVE_DIS});
      check(autosave_en, 0);
      pwr_fail_pin <= 1'b1;
      repeat (10) @(posedge mclk);
      check(n_auto, 0);
      pwr_fail_pin <= 1'b0;
      frame(1'b0, {`OP_AUTOSAVE_EN});
      check(autosave_en, 1);
      pwr_fail_pin <= 1'b1;
      repeat (10) @(posedge mclk);
      check(n_auto, 1);
      pwr_fail_pin <= 1'b0;
      store_active <= 1'b1; // Store in progress: ready bit and busy pin checked
      frame(1'b0, {`OP_RDSR, 8'h00});
      check(rxq[1], 8'h01);
      check(store_busy_pin_oe_n, 0);
      check(store_busy_pin_o, 0);
      store_active <= 1'b0;
      $display("Test autosave done");
   endtask : t_autosave
   task automatic t_unknown;
      int n0;
      n0 = n_strobe;
      frame(1'b0, {8'h1e, `OP_RDSR, 8'h00});
      check(n_strobe, n0);
      check(rxq[2], 8'hxx);
      $display("Test unknown opcode done");
   endtask : t_unknown
   initial begin
      sys_rst = 1'b1;
      pwr_fail_pin = 1'b0;
      store_active = 1'b0;
      rx_ready = 1'b0;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_powerup();
      t_write_queue();
      t_read();
      t_recall();
      t_autosave();
      t_unknown();
      end_of_test();
   end
   // Watchdog, well past the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : spi_nv_front_tb
`default_nettype wire
